// ---- pkg/light_link_pkg.sv ----
// Shared constants for the ambient light serial readout link
package light_link_pkg;
    localparam int FRAME_BITS = 16;
    localparam int LEAD_ZEROS = 3;
    localparam int VALUE_BITS = 8;
    localparam int TRAIL_ZEROS = FRAME_BITS - LEAD_ZEROS - VALUE_BITS;
    localparam logic [4:0] FIRST_VALUE_CYCLE = 5'h03;
    localparam logic [4:0] LAST_CYCLE = 5'h0F;
    localparam logic [7:0] SAMPLE_RESET = 8'h00;
    localparam int SYS_CLOCK_MHZ = 200;
    localparam int LINK_MIN_MHZ = 1;
    localparam int LINK_MAX_MHZ = 4;
    // Half period in system cycles; rounding keeps link at or below the maximum rate
    localparam int HALF_PERIOD_CYCLES =
        (SYS_CLOCK_MHZ + 2 * LINK_MAX_MHZ - 1) / (2 * LINK_MAX_MHZ);
    localparam int HALF_PERIOD_MAX = SYS_CLOCK_MHZ / (2 * LINK_MIN_MHZ);
    localparam logic [7:0] DIVIDER_RESET = 8'h00;
endpackage

// ---- pkg/light_link_if.sv ----
// Three-wire read-only serial link between host and light sensor
`timescale 1ns/10ps
interface light_link_if;
    logic selectN;
    logic serialClock;
    logic dataOut;
    modport host (output selectN, output serialClock, input dataOut);
    modport sensor (input selectN, input serialClock, output dataOut);
endinterface

// ---- logic/light_sensor_end.sv ----
// Sensor end: converts a light code and shifts it out on the link
`timescale 1ns/10ps
module light_sensor_end
    import light_link_pkg::*;
(
    light_link_if.sensor link,
    input wire logic [7:0] lightLevel
);
    // ---------------------------------------------------------------
    // Frame bit decode
    // ---------------------------------------------------------------
    // Zeros around the value, value MSB first
    function automatic logic frameBit(input logic [4:0] index, input logic [7:0] value);
        frameBit = 1'b0;
        if (index >= FIRST_VALUE_CYCLE && index < FIRST_VALUE_CYCLE + 5'h08)
        begin
            frameBit = value[3'(FIRST_VALUE_CYCLE + 5'h07 - index)];
        end
    endfunction

    logic [4:0] cycleCount, next_cycleCount;
    logic [7:0] levelMeta, next_levelMeta;
    logic [7:0] sample, next_sample;
    logic outBit, next_outBit;

    // ---------------------------------------------------------------
    // Shift out on falling edges
    // ---------------------------------------------------------------
    // Select high is the only reset. The level crosses in two stages on the
    // first two falling edges, well before the value bits are due.
    always_comb
    begin
        next_cycleCount = cycleCount;
        next_levelMeta = lightLevel;
        next_sample = sample;
        next_outBit = frameBit(cycleCount, sample);
        if (cycleCount <= LAST_CYCLE)
        begin
            next_cycleCount = cycleCount + 5'h01;
        end
        if (cycleCount == 5'h01)
        begin
            next_sample = levelMeta;
        end
    end

    always_ff @(negedge link.serialClock or posedge link.selectN)
    begin
        if (link.selectN)
        begin
            cycleCount <= 5'h00;
            levelMeta <= SAMPLE_RESET;
            sample <= SAMPLE_RESET;
            outBit <= 1'b0;
        end
        else
        begin
            cycleCount <= next_cycleCount;
            levelMeta <= next_levelMeta;
            sample <= next_sample;
            outBit <= next_outBit;
        end
    end

    // Data line only; no data input from the host exists
    assign link.dataOut = outBit;
endmodule

// ---- logic/light_host_end.sv ----
// Host end: generates select and link clock, reads one 16-cycle frame
`timescale 1ns/10ps
module light_host_end
    import light_link_pkg::*;
#(
    parameter int HALF_PERIOD = HALF_PERIOD_CYCLES
)
(
    input wire logic clock,
    input wire logic sys_rst,
    light_link_if.host link,
    input wire logic readRequest,
    output logic busy,
    output logic [7:0] lightValue,
    output logic valueValid
);
    // Operation
    // - Select low starts a conversion and report.
    // - One reading per sixteen link clock cycles.
    // - Host link clock between 1 and 4 MHz.
    // - Device shifts on falling, host samples rising.
    // - Three zeros, eight bits MSB first, zeros.
    // - Unsigned code, 0 dark, 255 bright.
    // - Read-only link, three wires only.

    // ---------------------------------------------------------------
    // Link rate limits
    // ---------------------------------------------------------------
    // An out-of-range setting is clamped, so the link never leaves 1..4 MHz
    localparam int HALF_USED = (HALF_PERIOD < HALF_PERIOD_CYCLES) ? HALF_PERIOD_CYCLES
        : (HALF_PERIOD > HALF_PERIOD_MAX) ? HALF_PERIOD_MAX : HALF_PERIOD;
    localparam logic [7:0] HALF_LAST = 8'(HALF_USED - 1);

    typedef enum logic [3:0] {
        IDLE = 4'b0001,
        SETUP = 4'b0010,
        SHIFT = 4'b0100,
        DONE = 4'b1000
    } state_type;

    state_type state, next_state;
    logic [7:0] divider, next_divider;
    logic halfTick;
    logic [4:0] cycles, next_cycles;
    logic clockLevel, next_clockLevel;
    logic selectLevel, next_selectLevel;
    logic [15:0] shiftIn, next_shiftIn;
    logic [7:0] next_lightValue;
    logic next_valueValid;
    logic dataMeta, dataSync;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic lastOfHalf(input logic [7:0] count);
        return count == HALF_LAST;
    endfunction

    // Value field of a captured frame, padding dropped
    function automatic logic [7:0] valueField(input logic [15:0] bits);
        return bits[TRAIL_ZEROS+VALUE_BITS-1:TRAIL_ZEROS];
    endfunction

    // ---------------------------------------------------------------
    // Input synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        dataMeta <= link.dataOut;
        dataSync <= dataMeta;
    end

    // ---------------------------------------------------------------
    // Half period divider
    // ---------------------------------------------------------------
    // Counts only inside a frame, so the first fall is a full half period late
    always_comb
    begin
        halfTick = 1'b0;
        next_divider = DIVIDER_RESET;
        if (state == SETUP || state == SHIFT)
        begin
            halfTick = lastOfHalf(divider);
            if (!halfTick)
            begin
                next_divider = divider + 8'h01;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            divider <= DIVIDER_RESET;
        end
        else
        begin
            divider <= next_divider;
        end
    end

    // ---------------------------------------------------------------
    // Frame sequencer
    // ---------------------------------------------------------------
    // Sampling the synchronised line at the rising edge is safe since
    // the device changed the bit a full half period before it, well past the two-stage delay.
    always_comb
    begin
        next_state = state;
        next_cycles = cycles;
        next_clockLevel = clockLevel;
        next_selectLevel = selectLevel;
        next_shiftIn = shiftIn;
        case (state)
            IDLE:
            begin
                next_clockLevel = 1'b1;
                next_selectLevel = 1'b1;
                if (readRequest)
                begin
                    next_selectLevel = 1'b0;
                    next_state = SETUP;
                end
            end
            SETUP:
            begin
                if (halfTick)
                begin
                    next_clockLevel = 1'b0;
                    next_cycles = 5'h00;
                    next_state = SHIFT;
                end
            end
            SHIFT:
            begin
                if (halfTick)
                begin
                    next_clockLevel = ~clockLevel;
                    if (!clockLevel)
                    begin
                        next_shiftIn = {shiftIn[14:0], dataSync};
                        next_cycles = cycles + 5'h01;
                        if (cycles == LAST_CYCLE)
                        begin
                            next_state = DONE;
                        end
                    end
                end
            end
            DONE:
            begin
                // Select rises one cycle after the last rising edge, never with it
                next_clockLevel = 1'b1;
                next_selectLevel = 1'b1;
                next_state = IDLE;
            end
            default:
            begin
                next_clockLevel = 1'b1;
                next_selectLevel = 1'b1;
                next_state = IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state <= IDLE;
            cycles <= 5'h00;
            clockLevel <= 1'b1;
            selectLevel <= 1'b1;
            shiftIn <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            cycles <= next_cycles;
            clockLevel <= next_clockLevel;
            selectLevel <= next_selectLevel;
            shiftIn <= next_shiftIn;
        end
    end

    // ---------------------------------------------------------------
    // Result
    // ---------------------------------------------------------------
    always_comb
    begin
        next_lightValue = lightValue;
        next_valueValid = 1'b0;
        if (state == DONE)
        begin
            next_lightValue = valueField(shiftIn);
            next_valueValid = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            lightValue <= SAMPLE_RESET;
            valueValid <= 1'b0;
        end
        else
        begin
            lightValue <= next_lightValue;
            valueValid <= next_valueValid;
        end
    end

    // Both link controls come straight from flip-flops, so the pins never glitch
    assign link.selectN = selectLevel;
    assign link.serialClock = clockLevel;
    assign busy = (state != IDLE);
endmodule

// ---- tb/light_link_props.sv ----
// Assertions on the light link wires
`timescale 1ns/10ps
module light_link_props
    import light_link_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic selectN,
    input wire logic serialClock,
    input wire logic dataOut
);
    logic [4:0] falls;
    logic [7:0] gap;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Link clock falls seen in the current frame
    always_ff @(posedge clock)
    begin
        if (selectN)
            falls <= 5'h00;
        else if ($fell(serialClock))
            falls <= falls + 5'h01;
    end
    // System cycles since the link clock last moved, saturating
    always_ff @(posedge clock)
    begin
        if (sys_rst || $changed(serialClock))
            gap <= 8'h00;
        else if (gap != 8'hFF)
            gap <= gap + 8'h01;
    end
    property p_idle; selectN |-> serialClock; endproperty
    a_idle: assert property (p_idle) else $error("link clock not idle");
    property p_start; $fell(selectN) |-> ##[1:110] $fell(serialClock); endproperty
    a_start: assert property (p_start) else $error("frame did not start");
    property p_hold; $fell(selectN) |=> !selectN [*8]; endproperty
    a_hold: assert property (p_hold) else $error("select dropped early");
    property p_count; $rose(selectN) |-> falls == 5'h10; endproperty
    a_count: assert property (p_count) else $error("frame length wrong");
    property p_slow; $changed(serialClock) |-> gap >= HALF_PERIOD_CYCLES - 1; endproperty
    a_slow: assert property (p_slow) else $error("link clock too fast");
    property p_fast; $fell(serialClock) |-> ##[1:100] $rose(serialClock); endproperty
    a_fast: assert property (p_fast) else $error("link clock too slow");
    property p_edge; !selectN && $stable(selectN) && $changed(dataOut)
        |-> $fell(serialClock); endproperty
    a_edge: assert property (p_edge) else $error("data moved off falling edge");
    property p_zero; !selectN && !$fell(serialClock) && ((falls != 5'h00 && falls < 5'h04)
        || falls > 5'h0B) |-> !dataOut; endproperty
    a_zero: assert property (p_zero) else $error("padding bit not zero");
endmodule

// ---- tb/ambient_light_spi_readout_bench.sv ----
// Bench joining host end and sensor end over the link
`timescale 1ns/10ps
`define CHK(what, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end
module ambient_light_spi_readout_bench;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic readRequest = 1'b0;
    logic [7:0] lightLevel = 8'h00;
    logic busy;
    logic [7:0] lightValue;
    logic valueValid;
    logic [15:0] frame;
    int bad_count = 0;
    int checks = 0;
    logic [7:0] levels [6] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h80, 8'h01};
    light_link_if link();
    light_sensor_end light_sensor_end_inst (.link(link), .lightLevel(lightLevel));
    light_host_end #(.HALF_PERIOD(25)) light_host_end_inst (.clock(clock), .sys_rst(sys_rst),
        .link(link), .readRequest(readRequest), .busy(busy), .lightValue(lightValue),
        .valueValid(valueValid));
    light_link_props light_link_props_inst (.clock(clock), .sys_rst(sys_rst),
        .selectN(link.selectN), .serialClock(link.serialClock), .dataOut(link.dataOut));
    always #2.5 clock = ~clock;
    // Wire-level capture, sampled on the rising link edge
    always @(posedge link.serialClock)
        if (!link.selectN)
            frame <= {frame[14:0], link.dataOut};
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Poke retries mid-frame with another level; it must be ignored
    task automatic readOnce(input logic [7:0] level, input logic poke);
        int n;
        @(posedge clock);
        lightLevel <= level;
        readRequest <= 1'b1;
        @(posedge clock);
        readRequest <= 1'b0;
        @(negedge clock);
        `CHK("busy", 1'b1, busy)
        if (poke)
        begin
            repeat (100) @(posedge clock);
            lightLevel <= ~level;
            readRequest <= 1'b1;
            @(posedge clock);
            readRequest <= 1'b0;
        end
        for (n = 0; n < 1000 && valueValid !== 1'b1; n++)
            @(negedge clock);
        `CHK("valueValid", 1'b1, valueValid)
        `CHK("lightValue", level, lightValue)
        `CHK("frame", {3'h0, level, 5'h00}, frame)
        `CHK("busy", 1'b0, busy)
        repeat (3) @(negedge clock);
        `CHK("busy", 1'b0, busy)
    endtask
    initial
    begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        foreach (levels[i])
            readOnce(levels[i], 1'b0);
        $display("test readings done");
        readOnce(8'h3C, 1'b1);
        $display("test busy refusal done");
        conclude();
    end
    initial
    begin
        #200000;
        bad_count++;
        conclude();
    end
endmodule
